/* sqe_top.sv */
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Functional notes
// RULE1: Queue enable selects queued transmit, redefined done
// RULE2: Queue off: single buffer, slots plain storage
// RULE3: Wrap restarts at slot zero, clears itself
// RULE4: Software sends long streams in sixteen-frame sets
// RULE5: Upper empty on slots 0-7 sent
// RULE6: Lower empty on slots 8-15 sent
// RULE7: Start needs enables, upper cleared, buffer empty
// RULE8: Empty flags interrupt only when enabled
// RULE9: Four-bit size, rewritable during transmission
// RULE10: Pending counts down, rolls to all ones
// RULE11: Transmit pointer selects next slot, test-writable
// RULE12: Done when pending all ones, shifter idle
// RULE13: Data register writes ignored in queued mode
// RULE14: Receive queue off: single buffer, plain storage
// RULE15: Errored frames stop queueing, pointer held
// RULE16: Upper full on slots 0-7 or completion
// RULE17: Lower full on slots 8-15 or completion
// RULE18: Software clears flags before queued reception
// RULE19: Full half: overflow, queue off, data held
// RULE20: Queued idle clears by status, slot read
// RULE21: Noisy frames still queued; noise clears likewise
// RULE22: Sixteen frames: both full, pointer zero
// RULE23: Size loads pending at start and wrap
// RULE24: Interrupt ORs enabled half flags, idle source
module sqe_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output sqe_pkg::sqe_tx_frame_t tx_out,
	input wire logic tx_take,
	input wire logic tx_shift_idle,
	input wire sqe_pkg::sqe_rx_frame_t rx_in,
	input wire logic rx_idle_line,
	output logic irq
);
	sqe_pkg::sqe_state_t st;
	sqe_pkg::sqe_state_t next_st;
	logic acc;
	logic rd_acc;
	logic wr_acc;
	logic tx_move;
	logic rx_try;
	logic rx_half_busy;
	logic done_cond;
	logic [31:0] rd_val;

	function automatic logic in_queue(input logic [9:0] a, input logic [9:0] base);
		return a[9:6] == base[9:6];
	endfunction

	// Zero wait state; read data latched in the setup cycle
	assign acc = ce & psel & penable & st.rd_ok;
	assign rd_acc = acc & ~pwrite;
	assign wr_acc = acc & pwrite;
	assign pready = psel & penable & st.rd_ok & ce;
	assign pslverr = pready & st.bad_addr;
	assign prdata = st.prdata;

	// RULE2: shifter sees the data register only
	assign tx_out = {~st.tx_buffer_empty & st.tx_on, st.tx_data};

	assign tx_move = st.tx_run & st.tx_buffer_empty & st.tx_on;
	assign rx_try = st.rx_queue_on & st.rx_on & st.rx_buffer_full & ~st.framing_fault
		& ~st.parity_fault & ~st.qflags[sqe_pkg::QF_OVF];
	assign rx_half_busy = st.rx_queue_pointer[3] ? st.qflags[sqe_pkg::QF_RXL] :
		st.qflags[sqe_pkg::QF_RXU];
	// RULE12: queued completion versus single-buffer completion
	assign done_cond = st.tx_queue_on ?
		(~st.tx_run & (st.pending_count == sqe_pkg::PEND_DONE) & st.tx_buffer_empty
		& tx_shift_idle) : (st.tx_buffer_empty & tx_shift_idle);

	// RULE8: each half flag gated by its own enable
	// RULE24: merged with the idle-line source
	assign irq = |(st.qflags[3:0] & st.irq_en) | (st.idle & st.idle_irq_en);

	always_comb begin
		rd_val = 32'h0000_0000;
		if (in_queue(paddr, sqe_pkg::ADDR_TXQ)) begin
			rd_val = {23'h000000, st.txq[paddr[5:2]]};
		end else if (in_queue(paddr, sqe_pkg::ADDR_RXQ)) begin
			rd_val = {23'h000000, st.rxq[paddr[5:2]]};
		end else begin
			case (paddr)
				sqe_pkg::ADDR_SCTRL: rd_val = {28'h0000000, st.test_mode, st.idle_irq_en,
					st.rx_on, st.tx_on};
				sqe_pkg::ADDR_SSTAT: rd_val = {24'h000000, st.parity_fault, st.framing_fault,
					st.overrun, st.noise_flag, st.idle, st.rx_buffer_full, st.tx_all_done,
					st.tx_buffer_empty};
				sqe_pkg::ADDR_SDATA: rd_val = {23'h000000, st.rx_data};
				sqe_pkg::ADDR_QCTRL: rd_val = {16'h0000, st.tx_queue_pointer, st.irq_en,
					1'b0, st.tx_queue_on, st.rx_queue_on, st.tx_wrap_allow, st.tx_size_code};
				sqe_pkg::ADDR_QSTAT: rd_val = {16'h0000, 3'h0, st.qflags,
					st.rx_queue_pointer, st.pending_count};
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		next_st = st;
		// Bus phases
		if (psel & ~penable) begin
			next_st.rd_ok = 1'b1;
			next_st.prdata = rd_val;
			next_st.bad_addr = ~(in_queue(paddr, sqe_pkg::ADDR_TXQ)
				| in_queue(paddr, sqe_pkg::ADDR_RXQ) | paddr == sqe_pkg::ADDR_SCTRL
				| paddr == sqe_pkg::ADDR_SSTAT | paddr == sqe_pkg::ADDR_SDATA
				| paddr == sqe_pkg::ADDR_QCTRL | paddr == sqe_pkg::ADDR_QSTAT);
		end
		if (acc) begin
			next_st.rd_ok = 1'b0;
		end
		// Read side effects: status reads arm, data reads clear
		if (rd_acc & ~st.bad_addr) begin
			if (paddr == sqe_pkg::ADDR_QSTAT) begin
				next_st.arm_q = st.arm_q | st.qflags;
			end
			if (paddr == sqe_pkg::ADDR_SSTAT) begin
				next_st.arm_done = st.arm_done | st.tx_all_done;
				next_st.arm_idle = st.arm_idle | st.idle;
				next_st.arm_noise = st.arm_noise | st.noise_flag;
				next_st.arm_err = st.arm_err | st.rx_buffer_full | st.overrun
					| st.framing_fault | st.parity_fault;
			end
			if (paddr == sqe_pkg::ADDR_SDATA & st.arm_err) begin
				next_st.rx_buffer_full = 1'b0;
				next_st.overrun = 1'b0;
				next_st.framing_fault = 1'b0;
				next_st.parity_fault = 1'b0;
				next_st.arm_err = 1'b0;
			end
			// RULE20: queued idle clears on a queue slot read
			// RULE21: noise flag follows the same path
			if ((st.rx_queue_on & in_queue(paddr, sqe_pkg::ADDR_RXQ))
				| (~st.rx_queue_on & paddr == sqe_pkg::ADDR_SDATA)) begin
				if (st.arm_idle) begin
					next_st.idle = 1'b0;
					next_st.arm_idle = 1'b0;
				end
				if (st.arm_noise) begin
					next_st.noise_flag = 1'b0;
					next_st.arm_noise = 1'b0;
				end
			end
		end
		// Register writes
		if (wr_acc & ~st.bad_addr) begin
			if (paddr == sqe_pkg::ADDR_SCTRL) begin
				next_st.tx_on = pwdata[sqe_pkg::SC_TX_ON];
				next_st.rx_on = pwdata[sqe_pkg::SC_RX_ON];
				next_st.idle_irq_en = pwdata[sqe_pkg::SC_IDLE_EN];
				next_st.test_mode = pwdata[sqe_pkg::SC_TEST];
			end
			if (paddr == sqe_pkg::ADDR_QCTRL) begin
				// RULE11: pointer writable only in test mode
				if (st.test_mode) begin
					next_st.tx_queue_pointer = pwdata[sqe_pkg::QC_PTR_LO +: 4];
				end
				next_st.irq_en = pwdata[sqe_pkg::QC_TXLE_EN +: 4];
				// RULE1: queued transmit mode select
				next_st.tx_queue_on = pwdata[sqe_pkg::QC_TXQ_ON];
				next_st.rx_queue_on = pwdata[sqe_pkg::QC_RXQ_ON];
				next_st.tx_wrap_allow = pwdata[sqe_pkg::QC_WRAP];
				// RULE9: size may change mid-stream
				next_st.tx_size_code = pwdata[sqe_pkg::QC_SIZE_LO +: 4];
			end
			if (paddr == sqe_pkg::ADDR_QSTAT) begin
				for (int i = 0; i < 5; i++) begin
					if (~pwdata[sqe_pkg::QS_FLAG_LO + i] & st.arm_q[i]) begin
						next_st.qflags[i] = 1'b0;
						next_st.arm_q[i] = 1'b0;
					end
				end
				// RULE10: pending and receive pointer test-writable only
				if (st.test_mode) begin
					next_st.rx_queue_pointer = pwdata[sqe_pkg::QS_RXPTR_LO +: 4];
					next_st.pending_count = pwdata[sqe_pkg::QS_PEND_LO +: 4];
				end
			end
			// RULE13: data register ignored while queue on
			if (paddr == sqe_pkg::ADDR_SDATA & ~st.tx_queue_on) begin
				next_st.tx_data = pwdata[8:0];
				next_st.tx_buffer_empty = 1'b0;
				if (st.arm_done) begin
					next_st.tx_all_done = 1'b0;
					next_st.arm_done = 1'b0;
				end
			end
			if (in_queue(paddr, sqe_pkg::ADDR_TXQ)) begin
				next_st.txq[paddr[5:2]] = pwdata[8:0];
				// RULE12: done clears on a queue slot write
				if (st.tx_queue_on & st.arm_done) begin
					next_st.tx_all_done = 1'b0;
					next_st.arm_done = 1'b0;
				end
			end
			// RULE14: receive slots are plain storage to software
			if (in_queue(paddr, sqe_pkg::ADDR_RXQ)) begin
				next_st.rxq[paddr[5:2]] = pwdata[8:0];
			end
		end
		// Transmit shifter hand-off
		if (tx_take & ~st.tx_buffer_empty & st.tx_on) begin
			next_st.tx_buffer_empty = 1'b1;
		end
		// RULE7: run starts once software has primed the queue
		if (~st.tx_run & st.tx_queue_on & st.tx_on & ~st.qflags[sqe_pkg::QF_TXU]
			& st.tx_buffer_empty) begin
			next_st.tx_run = 1'b1;
			// RULE23: size copied at queue start
			next_st.pending_count = st.tx_size_code;
			next_st.tx_queue_pointer = 4'h0;
		end
		if (tx_move) begin
			next_st.tx_data = st.txq[st.tx_queue_pointer];
			next_st.tx_buffer_empty = 1'b0;
			next_st.tx_queue_pointer = st.tx_queue_pointer + 4'h1;
			// RULE10: 0 rolls over to all ones
			next_st.pending_count = st.pending_count - 4'h1;
			// RULE5: upper half drained
			if (st.tx_queue_pointer == sqe_pkg::SLOT_UPPER_LAST) begin
				next_st.qflags[sqe_pkg::QF_TXU] = 1'b1;
			end
			// RULE6: lower half drained
			if (st.tx_queue_pointer == sqe_pkg::SLOT_LAST) begin
				next_st.qflags[sqe_pkg::QF_TXL] = 1'b1;
			end
			if (st.pending_count == sqe_pkg::PEND_LAST) begin
				if (st.tx_queue_pointer == sqe_pkg::SLOT_LAST & next_st.tx_wrap_allow) begin
					// RULE3: wrap to slot zero, self-clearing
					next_st.tx_queue_pointer = 4'h0;
					next_st.tx_wrap_allow = 1'b0;
					// RULE23: reload uses the newest size
					next_st.pending_count = next_st.tx_size_code;
				end else begin
					// RULE5: completion sets both empty flags
					next_st.tx_run = 1'b0;
					next_st.qflags[sqe_pkg::QF_TXU] = 1'b1;
					next_st.qflags[sqe_pkg::QF_TXL] = 1'b1;
				end
			end
		end
		if (~next_st.tx_queue_on) begin
			next_st.tx_run = 1'b0;
		end
		// RULE12: done is an edge, so a clear is not undone at once
		next_st.done_prev = done_cond;
		if (done_cond & ~st.done_prev) begin
			next_st.tx_all_done = 1'b1;
		end
		// RULE15: errored frame blocks the queue, pointer held
		if (rx_try) begin
			if (rx_half_busy) begin
				// RULE19: overflow, queue off, frame kept in data register
				next_st.qflags[sqe_pkg::QF_OVF] = 1'b1;
				next_st.rx_queue_on = 1'b0;
			end else begin
				next_st.rxq[st.rx_queue_pointer] = st.rx_data;
				next_st.rx_buffer_full = 1'b0;
				next_st.rx_queue_pointer = st.rx_queue_pointer + 4'h1;
				// RULE16: upper half filled
				if (st.rx_queue_pointer == sqe_pkg::SLOT_UPPER_LAST) begin
					next_st.qflags[sqe_pkg::QF_RXU] = 1'b1;
				end
				// RULE22: pointer wraps to zero after slot 15
				if (st.rx_queue_pointer == sqe_pkg::SLOT_LAST) begin
					next_st.qflags[sqe_pkg::QF_RXL] = 1'b1;
				end
			end
		end
		// RULE21: noisy frames accepted like clean ones
		if (rx_in.valid & st.rx_on) begin
			if (next_st.rx_buffer_full) begin
				next_st.overrun = 1'b1;
			end else begin
				next_st.rx_data = rx_in.data;
				next_st.rx_buffer_full = 1'b1;
				// Built on next_st so a same-cycle clear is not undone
				next_st.framing_fault = next_st.framing_fault | rx_in.framing;
				next_st.parity_fault = next_st.parity_fault | rx_in.parity;
				next_st.noise_flag = next_st.noise_flag | rx_in.noise;
			end
		end
		// RULE17: idle ends reception, flagging a partial half
		next_st.idle_prev = rx_idle_line;
		if (rx_idle_line & ~st.idle_prev) begin
			next_st.idle = 1'b1;
			if (st.rx_queue_on & next_st.rx_queue_pointer[2:0] != 3'h0) begin
				if (next_st.rx_queue_pointer[3]) begin
					next_st.qflags[sqe_pkg::QF_RXL] = 1'b1;
				end else begin
					next_st.qflags[sqe_pkg::QF_RXU] = 1'b1;
				end
			end
		end
	end

	// Clock enable freezes everything, including bus completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.qflags <= sqe_pkg::QFLAGS_RST;
			st.tx_buffer_empty <= sqe_pkg::TX_EMPTY_RST;
			st.tx_all_done <= sqe_pkg::TX_DONE_RST;
			st.done_prev <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	data_ignore_a: assert property ( // RULE13
		wr_acc & paddr == sqe_pkg::ADDR_SDATA & st.tx_queue_on & ~tx_move
		|=> $stable(st.tx_data))
		else $error("data register write took effect in queued mode");
	wrap_restart_a: assert property ( // RULE3
		ce & tx_move & st.pending_count == sqe_pkg::PEND_LAST
		& st.tx_queue_pointer == sqe_pkg::SLOT_LAST & st.tx_wrap_allow & ~wr_acc
		|=> st.tx_queue_pointer == 4'h0 & ~st.tx_wrap_allow & st.tx_run)
		else $error("wrap did not restart at slot zero");
	upper_empty_a: assert property ( // RULE5
		ce & tx_move & st.tx_queue_pointer == sqe_pkg::SLOT_UPPER_LAST
		|=> st.qflags[sqe_pkg::QF_TXU] & st.tx_queue_pointer == 4'h8)
		else $error("upper empty flag missing after slot 7");
	lower_empty_a: assert property ( // RULE6
		ce & tx_move & st.tx_queue_pointer == sqe_pkg::SLOT_LAST
		|=> st.qflags[sqe_pkg::QF_TXL])
		else $error("lower empty flag missing after slot 15");
	pend_roll_a: assert property ( // RULE10
		ce & tx_move & st.pending_count == sqe_pkg::PEND_LAST
		& ~(st.tx_queue_pointer == sqe_pkg::SLOT_LAST & st.tx_wrap_allow) & ~wr_acc
		|=> st.pending_count == sqe_pkg::PEND_DONE & ~st.tx_run)
		else $error("pending count did not roll to all ones");
	irq_gate_a: assert property ( // RULE8
		~st.irq_en[sqe_pkg::QF_TXU] & ~st.irq_en[sqe_pkg::QF_TXL] & ~st.irq_en[sqe_pkg::QF_RXU]
		& ~st.irq_en[sqe_pkg::QF_RXL] & ~st.idle_irq_en |-> ~irq)
		else $error("interrupt raised with every enable clear");
	rx_overflow_a: assert property ( // RULE19
		ce & rx_try & rx_half_busy
		|=> st.qflags[sqe_pkg::QF_OVF] & ~st.rx_queue_on & st.rx_buffer_full
		& $stable(st.rx_data))
		else $error("overflow did not stop the receive queue");
	rx_error_hold_a: assert property ( // RULE15
		ce & st.rx_queue_on & st.rx_buffer_full & st.framing_fault & ~acc
		|=> $stable(st.rx_queue_pointer) & st.rx_buffer_full)
		else $error("errored frame entered the receive queue");
	rx_wrap_a: assert property ( // RULE22
		ce & rx_try & ~rx_half_busy & st.rx_queue_pointer == sqe_pkg::SLOT_LAST
		|=> st.rx_queue_pointer == 4'h0 & st.qflags[sqe_pkg::QF_RXL])
		else $error("receive pointer did not return to zero");
	done_set_a: assert property ( // RULE12
		ce & st.tx_queue_on & done_cond & ~st.done_prev |=> st.tx_all_done)
		else $error("transmit done not set at queue end");
	bus_answer_a: assert property (
		psel & ~penable & ce |=> pready | ~(psel & penable & ce))
		else $error("access phase not answered at once");

	full_queue_c: cover property (ce & rx_try & ~rx_half_busy
		& st.rx_queue_pointer == sqe_pkg::SLOT_LAST);
	wrap_seen_c: cover property (ce & tx_move & st.tx_wrap_allow
		& st.pending_count == sqe_pkg::PEND_LAST);
	overflow_c: cover property (ce & rx_try & rx_half_busy);
	done_c: cover property (st.tx_queue_on & st.tx_all_done & ~st.tx_run);
endmodule

/* sqe_pkg.sv */
package sqe_pkg;
	localparam int unsigned QDEPTH = 16;
	localparam int unsigned FRAME_W = 9;
	// Register byte addresses; the two queue registers are built from word indices
	localparam logic [9:0] ADDR_SCTRL = 10'h000;
	localparam logic [9:0] ADDR_SSTAT = 10'h004;
	localparam logic [9:0] ADDR_SDATA = 10'h008;
	localparam logic [9:0] QCTRL_INDEX = 10'h028;
	localparam logic [9:0] QSTAT_INDEX = 10'h02a;
	localparam logic [9:0] ADDR_QCTRL = {QCTRL_INDEX[7:0], 2'b00};
	localparam logic [9:0] ADDR_QSTAT = {QSTAT_INDEX[7:0], 2'b00};
	localparam logic [9:0] ADDR_TXQ = 10'h100;
	localparam logic [9:0] ADDR_RXQ = 10'h140;
	// Queue control fields
	localparam int QC_PTR_LO = 12;
	localparam int QC_RXUF_EN = 11;
	localparam int QC_RXLF_EN = 10;
	localparam int QC_TXUE_EN = 9;
	localparam int QC_TXLE_EN = 8;
	localparam int QC_TXQ_ON = 6;
	localparam int QC_RXQ_ON = 5;
	localparam int QC_WRAP = 4;
	localparam int QC_SIZE_LO = 0;
	// Queue status fields; flag vector index = bit - QS_FLAG_LO
	localparam int QS_FLAG_LO = 8;
	localparam int QS_RXPTR_LO = 4;
	localparam int QS_PEND_LO = 0;
	localparam int QF_TXL = 0;
	localparam int QF_TXU = 1;
	localparam int QF_RXL = 2;
	localparam int QF_RXU = 3;
	localparam int QF_OVF = 4;
	// Serial control fields
	localparam int SC_TX_ON = 0;
	localparam int SC_RX_ON = 1;
	localparam int SC_IDLE_EN = 2;
	localparam int SC_TEST = 3;
	// Reset values
	localparam logic [4:0] QFLAGS_RST = 5'h0f;
	localparam logic TX_EMPTY_RST = 1'b1;
	localparam logic TX_DONE_RST = 1'b1;
	// Counter landmarks
	localparam logic [3:0] PEND_DONE = 4'hf;
	localparam logic [3:0] PEND_LAST = 4'h0;
	localparam logic [3:0] SLOT_UPPER_LAST = 4'h7;
	localparam logic [3:0] SLOT_LAST = 4'hf;

	typedef struct packed {
		logic valid;
		logic [8:0] data;
		logic framing;
		logic parity;
		logic noise;
	} sqe_rx_frame_t;

	typedef struct packed {
		logic valid;
		logic [8:0] data;
	} sqe_tx_frame_t;

	typedef struct packed {
		logic [15:0][8:0] txq;
		logic [15:0][8:0] rxq;
		logic [8:0] tx_data;
		logic [8:0] rx_data;
		logic tx_buffer_empty;
		logic tx_all_done;
		logic rx_buffer_full;
		logic idle;
		logic overrun;
		logic noise_flag;
		logic framing_fault;
		logic parity_fault;
		logic tx_on;
		logic rx_on;
		logic idle_irq_en;
		logic test_mode;
		logic [3:0] tx_queue_pointer;
		logic [3:0] irq_en;
		logic tx_queue_on;
		logic rx_queue_on;
		logic tx_wrap_allow;
		logic [3:0] tx_size_code;
		logic [4:0] qflags;
		logic [3:0] rx_queue_pointer;
		logic [3:0] pending_count;
		logic [4:0] arm_q;
		logic arm_done;
		logic arm_idle;
		logic arm_noise;
		logic arm_err;
		logic tx_run;
		logic done_prev;
		logic idle_prev;
		logic rd_ok;
		logic bad_addr;
		logic [31:0] prdata;
	} sqe_state_t;
endpackage

/* sqe_partner.sv */
`timescale 1ns/1ps
module sqe_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] gap,
	input wire sqe_pkg::sqe_tx_frame_t tx_out,
	output logic tx_take,
	output logic tx_shift_idle,
	output sqe_pkg::sqe_rx_frame_t rx_in,
	output logic rx_idle_line
);
	logic [8:0] got[$];
	logic [3:0] wait_cnt;
	logic [2:0] shift_cnt;

	assign tx_shift_idle = (shift_cnt == 3'h0);
	initial rx_in = '0;
	initial rx_idle_line = 1'b0;

	// Takes a frame only once the previous one has shifted out
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_take <= 1'b0;
			wait_cnt <= 4'h0;
			shift_cnt <= 3'h0;
		end else begin
			tx_take <= 1'b0;
			if (shift_cnt != 3'h0) begin
				shift_cnt <= shift_cnt - 3'h1;
			end
			if (tx_out.valid && !tx_take && tx_shift_idle) begin
				if (wait_cnt >= gap) begin
					tx_take <= 1'b1;
					wait_cnt <= 4'h0;
					shift_cnt <= 3'h4;
					got.push_back(tx_out.data);
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end

	// Data lines toggle when no frame is offered
	task automatic send(input logic [8:0] d, input logic nf, input logic fe);
		@(posedge pclk);
		rx_in <= '{valid: 1'b1, data: d, framing: fe, parity: 1'b0, noise: nf};
		@(posedge pclk);
		rx_in <= '{valid: 1'b0, data: ~d, framing: 1'b1, parity: 1'b1, noise: ~nf};
		repeat (3) @(posedge pclk);
	endtask

	// Line goes idle for a few cycles, one rising edge
	task automatic idle_line();
		@(posedge pclk);
		rx_idle_line <= 1'b1;
		repeat (3) @(posedge pclk);
		rx_idle_line <= 1'b0;
		@(posedge pclk);
	endtask
endmodule

/* sqe_tb_top.sv */
`timescale 1ns/1ps
module sqe_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic tx_take;
	logic tx_shift_idle;
	logic rx_idle_line;
	logic [3:0] gap = 4'h4;
	sqe_pkg::sqe_tx_frame_t tx_out;
	sqe_pkg::sqe_rx_frame_t rx_in;
	logic [31:0] r;
	logic e;
	int num_errors = 0;
	int cmp_count = 0;

	always #5 pclk = ~pclk;

	sqe_top sqe_top_i (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_out(tx_out), .tx_take(tx_take),
		.tx_shift_idle(tx_shift_idle), .rx_in(rx_in), .rx_idle_line(rx_idle_line),
		.irq(irq)
	);

	sqe_partner sqe_partner_i (
		.pclk(pclk), .presetn(presetn), .gap(gap), .tx_out(tx_out), .tx_take(tx_take),
		.tx_shift_idle(tx_shift_idle), .rx_in(rx_in), .rx_idle_line(rx_idle_line)
	);

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One idle cycle after each transfer keeps strobes single-driven
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [9:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] txv(input int i);
		return (32'h100 + 32'(i) * 32'h11) & 32'h1ff;
	endfunction

	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r, 32'h0000_0f00);
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0);
		rd(10'h3fc);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(sqe_pkg::ADDR_TXQ + 10'h014, 32'hffff_fe5a);
		rd(sqe_pkg::ADDR_TXQ + 10'h014);
		chk(r, 32'h0000_005a);
		wr(sqe_pkg::ADDR_RXQ + 10'h024, 32'h0000_01cd);
		rd(sqe_pkg::ADDR_RXQ + 10'h024);
		chk(r, 32'h0000_01cd);
		rd(sqe_pkg::ADDR_QSTAT);
		wr(sqe_pkg::ADDR_QSTAT, 32'h0);
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r, 32'h0);
		// full set with wrap, short final set
		rd(sqe_pkg::ADDR_SSTAT);
		wr(sqe_pkg::ADDR_QCTRL, 32'h35f);
		for (int i = 0; i < 16; i++) wr(sqe_pkg::ADDR_TXQ + 10'(4 * i), txv(i));
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h2, 32'h0);
		wr(sqe_pkg::ADDR_SCTRL, 32'h1);
		wr(sqe_pkg::ADDR_SDATA, 32'h055);
		wr(sqe_pkg::ADDR_QCTRL, 32'h352);
		gap <= 4'h0;
		for (int n = 0; n < 3000 && sqe_partner_i.got.size() < 19; n++) @(posedge pclk);
		for (int n = 0; n < 20; n++) begin
			rd(sqe_pkg::ADDR_SSTAT);
			if (r[1] === 1'b1) break;
		end
		chk(r & 32'h2, 32'h2);
		chk(32'(sqe_partner_i.got.size()), 32'h13);
		for (int i = 0; i < 19; i++) begin
			chk(32'(sqe_partner_i.got[i]), txv(i < 16 ? i : i - 16));
		end
		rd(sqe_pkg::ADDR_QCTRL);
		chk(r & 32'h10, 32'h0);
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r, 32'h0000_030f);
		chk({31'h0, irq}, 32'h1);
		wr(sqe_pkg::ADDR_TXQ, txv(0));
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h2, 32'h0);
		wr(sqe_pkg::ADDR_QCTRL, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(sqe_pkg::ADDR_QSTAT, 32'h0);
		wr(sqe_pkg::ADDR_SCTRL, 32'h2);
		wr(sqe_pkg::ADDR_QCTRL, 32'hc20);
		for (int i = 0; i < 16; i++) sqe_partner_i.send(9'h0a0 + 9'(i), i == 3, 1'b0);
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r & 32'h1ff0, 32'h0c00);
		chk({31'h0, irq}, 32'h1);
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h10, 32'h10);
		for (int i = 0; i < 16; i++) begin
			rd(sqe_pkg::ADDR_RXQ + 10'(4 * i));
			chk(r, 32'h0a0 + 32'(i));
		end
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h10, 32'h0);
		// Both halves still full, so this frame must not enter
		sqe_partner_i.send(9'h1ee, 1'b0, 1'b0);
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r & 32'h1000, 32'h1000);
		rd(sqe_pkg::ADDR_QCTRL);
		chk(r & 32'h20, 32'h0);
		rd(sqe_pkg::ADDR_SDATA);
		chk(r, 32'h0000_01ee);
		rd(sqe_pkg::ADDR_SSTAT);
		rd(sqe_pkg::ADDR_SDATA);
		rd(sqe_pkg::ADDR_QSTAT);
		wr(sqe_pkg::ADDR_QSTAT, 32'h0);
		wr(sqe_pkg::ADDR_QCTRL, 32'hc20);
		for (int i = 0; i < 3; i++) sqe_partner_i.send(9'h0b0 + 9'(i), 1'b0, 1'b0);
		// Framed badly, so it stays in the data register
		sqe_partner_i.send(9'h111, 1'b0, 1'b1);
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r & 32'h10f0, 32'h0030);
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h44, 32'h44);
		sqe_partner_i.idle_line();
		rd(sqe_pkg::ADDR_QSTAT);
		chk(r & 32'h1ff0, 32'h0830);
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h8, 32'h8);
		rd(sqe_pkg::ADDR_SDATA);
		chk(r, 32'h0000_0111);
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h8, 32'h8);
		rd(sqe_pkg::ADDR_RXQ);
		chk(r, 32'h0000_00b0);
		rd(sqe_pkg::ADDR_SSTAT);
		chk(r & 32'h8, 32'h0);
		summarize();
	end
endmodule
